// ### hw/asc_top.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module asc_top
  import asc_pkg::*;
#(
  parameter int LEVEL_W = 4,
  parameter int TH_W = 3
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ASC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ASC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // mode and levels from the controller
  input wire logic master_mode,
  input wire logic [LEVEL_W-1:0] tx_level,
  input wire logic [LEVEL_W-1:0] rx_level,
  input wire logic [TH_W-1:0] tx_level_threshold,
  input wire logic [TH_W-1:0] rx_level_threshold,
  // event flags from the controller
  input wire logic left_zero_cross_flag,
  input wire logic right_zero_cross_flag,
  input wire logic tx_overflow_flag,
  input wire logic tx_underflow_flag,
  input wire logic rx_overflow_flag,
  // receive fifo read by software
  input wire logic rx_fifo_read,
  input wire logic rx_fifo_empty,
  // results
  output logic rx_underflow_flag,
  output logic bit_clock,
  output logic bit_clock_edge,
  output logic master_clock,
  output logic irq
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [ASC_BCD_W-1:0] bcd_ff;
  logic [ASC_MCD_W-1:0] mcd_ff;
  logic [31:0] ien_ff;
  logic rxud_ff;
  logic irq_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [ASC_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;
  logic rd_fire;
  logic rxud_set;
  logic rxud_clr;
  logic [31:0] evt_vec;
  logic [31:0] nxt_ien;
  logic [31:0] nxt_clkdiv;
  logic [31:0] clkdiv_rd;

  asc_div_if dv_if ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // merge byte lanes chosen by the write strobes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // true for an offset that holds a register
  function automatic logic reg_hit(input logic [ASC_ADDR_W-1:0] a);
    return (a == ASC_OFF_CLKDIV) || (a == ASC_OFF_IEN) || (a == ASC_OFF_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------
  // each channel accepted on its own, one write in flight
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

  // capture write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_ff <= 1'b0;
    end
  end

  // capture write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_ff <= 1'b0;
    end
  end

  // write response, slverr on an unmapped offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= ASC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= reg_hit(awaddr_ff) ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  assign clkdiv_rd = {16'h0000, bcd_ff, 5'h00, mcd_ff};
  assign nxt_clkdiv = lane_merge(clkdiv_rd, wdata_ff, wstrb_ff);
  assign nxt_ien = lane_merge(ien_ff, wdata_ff, wstrb_ff) & ASC_IEN_MASK;

  // clock divider register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcd_ff <= ASC_BCD_RST;
      mcd_ff <= ASC_MCD_RST;
    end else if (wr_fire && awaddr_ff == ASC_OFF_CLKDIV) begin
      bcd_ff <= nxt_clkdiv[ASC_BCD_LSB +: ASC_BCD_W];
      mcd_ff <= nxt_clkdiv[ASC_MCD_LSB +: ASC_MCD_W];
    end
  end

  // interrupt enable register, reserved bits kept zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_ff <= ASC_IEN_RST;
    end else if (wr_fire && awaddr_ff == ASC_OFF_IEN) begin
      ien_ff <= nxt_ien;
    end
  end

  // ----------------------------------------------------------------
  // receive underflow flag
  // ----------------------------------------------------------------
  assign rxud_set = rx_fifo_read && rx_fifo_empty;
  assign rxud_clr = wr_fire && awaddr_ff == ASC_OFF_STATUS &&
                    wstrb_ff[0] && wdata_ff[ASC_STAT_RXUD_CLR];

  // set on an empty read; a set in the clear cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxud_ff <= 1'b0;
    end else if (rxud_set) begin
      rxud_ff <= 1'b1;
    end else if (rxud_clr) begin
      rxud_ff <= 1'b0;
    end
  end

  assign rx_underflow_flag = rxud_ff;

  // ----------------------------------------------------------------
  // interrupt gating
  // ----------------------------------------------------------------
  // events laid out at the positions of their enable bits
  always_comb begin
    evt_vec = '0;
    evt_vec[ASC_IEN_LZC] = left_zero_cross_flag;
    evt_vec[ASC_IEN_RZC] = right_zero_cross_flag;
    evt_vec[ASC_IEN_TXLVL] = tx_level < LEVEL_W'(tx_level_threshold);
    evt_vec[ASC_IEN_TXOV] = tx_overflow_flag;
    evt_vec[ASC_IEN_TXUD] = tx_underflow_flag;
    evt_vec[ASC_IEN_RXLVL] = rx_level >= LEVEL_W'(rx_level_threshold);
    evt_vec[ASC_IEN_RXOV] = rx_overflow_flag;
    evt_vec[ASC_IEN_RXUD] = rxud_ff;
  end

  // one registered line for all enabled events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evt_vec & ien_ff);
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // read data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= ASC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= reg_hit(s_axi_araddr) ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
      unique case (s_axi_araddr)
        ASC_OFF_CLKDIV: rdata_ff <= clkdiv_rd;
        ASC_OFF_IEN: rdata_ff <= ien_ff;
        ASC_OFF_STATUS: rdata_ff <= evt_vec;
        default: rdata_ff <= '0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ----------------------------------------------------------------
  // clock divider
  // ----------------------------------------------------------------
  assign dv_if.bit_clock_divisor = bcd_ff;
  assign dv_if.master_clock_divisor = mcd_ff;
  assign dv_if.master_mode = master_mode;

  asc_clk_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .dv(dv_if.div)
  );

  assign bit_clock = dv_if.bclk;
  assign bit_clock_edge = dv_if.bclk_edge;
  // divisor zero hands the input clock straight through
  assign master_clock = (mcd_ff == 3'h0) ? aclk : dv_if.mclk_div;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_lzc;
    @(posedge aclk) disable iff (!aresetn)
    (ien_ff[ASC_IEN_LZC] && left_zero_cross_flag) |=> irq;
  endproperty
  a_lzc: assert property (p_lzc) else $error("left zero cross did not interrupt");

  property p_rzc;
    @(posedge aclk) disable iff (!aresetn)
    (ien_ff[ASC_IEN_RZC] && right_zero_cross_flag) |=> irq;
  endproperty
  a_rzc: assert property (p_rzc) else $error("right zero cross did not interrupt");

  property p_txlvl;
    @(posedge aclk) disable iff (!aresetn)
    (ien_ff[ASC_IEN_TXLVL] && tx_level < LEVEL_W'(tx_level_threshold)) |=> irq;
  endproperty
  a_txlvl: assert property (p_txlvl) else $error("tx level did not interrupt");

  property p_txov;
    @(posedge aclk) disable iff (!aresetn)
    (ien_ff[ASC_IEN_TXOV] && tx_overflow_flag) |=> irq;
  endproperty
  a_txov: assert property (p_txov) else $error("tx overflow did not interrupt");

  property p_txud;
    @(posedge aclk) disable iff (!aresetn)
    (ien_ff[ASC_IEN_TXUD] && tx_underflow_flag) |=> irq;
  endproperty
  a_txud: assert property (p_txud) else $error("tx underflow did not interrupt");

  property p_rxlvl;
    @(posedge aclk) disable iff (!aresetn)
    (ien_ff[ASC_IEN_RXLVL] && rx_level >= LEVEL_W'(rx_level_threshold)) |=> irq;
  endproperty
  a_rxlvl: assert property (p_rxlvl) else $error("rx level did not interrupt");

  property p_rxov;
    @(posedge aclk) disable iff (!aresetn)
    (ien_ff[ASC_IEN_RXOV] && rx_overflow_flag) |=> irq;
  endproperty
  a_rxov: assert property (p_rxov) else $error("rx overflow did not interrupt");

  property p_rxud;
    @(posedge aclk) disable iff (!aresetn)
    (rx_fifo_read && rx_fifo_empty) |=> rx_underflow_flag ##1
    (!$past(ien_ff[ASC_IEN_RXUD]) || irq);
  endproperty
  a_rxud: assert property (p_rxud) else $error("empty read lost underflow");

  property p_quiet;
    @(posedge aclk) disable iff (!aresetn)
    (ien_ff == 32'h0) ##1 (ien_ff == 32'h0) |-> !irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt with all enables off");

  property p_ien_rsvd;
    @(posedge aclk) disable iff (!aresetn)
    (ien_ff & ~ASC_IEN_MASK) == 32'h0;
  endproperty
  a_ien_rsvd: assert property (p_ien_rsvd) else $error("reserved enable bit set");

  property p_wr_resp;
    @(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

endmodule
`default_nettype wire

// ### hw/asc_pkg.sv
// What this block does
// - in master mode the block makes the bit clock; software sets its rate.
// - bit clock equals divider input clock over twice (bit clock divisor plus one).
// - master clock divisor zero passes the divider input clock straight out.
// - nonzero master clock divisor gives input clock over twice the divisor.
// - left zero-cross enable set lets a left zero-cross event interrupt.
// - right zero-cross enable set lets a right zero-cross event interrupt.
// - tx level enable set interrupts while tx word count is below tx threshold.
// - tx overflow enable set interrupts while the tx overflow flag is one.
// - tx underflow enable set interrupts while the tx underflow flag is one.
// - rx level enable set interrupts while rx word count reaches rx threshold.
// - enable bit 1 gates the rx overflow interrupt.
// - reading an empty rx fifo sets the rx underflow flag; bit 0 gates it.
package asc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ASC_ADDR_W = 8;
  localparam logic [7:0] ASC_OFF_CLKDIV = 8'h04;
  localparam logic [7:0] ASC_OFF_IEN = 8'h08;
  localparam logic [7:0] ASC_OFF_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int ASC_BCD_LSB = 8;
  localparam int ASC_BCD_W = 8;
  localparam int ASC_MCD_LSB = 0;
  localparam int ASC_MCD_W = 3;
  localparam int ASC_IEN_LZC = 12;
  localparam int ASC_IEN_RZC = 11;
  localparam int ASC_IEN_TXLVL = 10;
  localparam int ASC_IEN_TXOV = 9;
  localparam int ASC_IEN_TXUD = 8;
  localparam int ASC_IEN_RXLVL = 2;
  localparam int ASC_IEN_RXOV = 1;
  localparam int ASC_IEN_RXUD = 0;
  localparam logic [31:0] ASC_IEN_MASK = 32'h0000_1f07;
  localparam logic [31:0] ASC_IEN_RST = 32'h0000_0000;
  localparam logic [7:0] ASC_BCD_RST = 8'h00;
  localparam logic [2:0] ASC_MCD_RST = 3'h0;
  localparam int ASC_STAT_RXUD_CLR = 0;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] ASC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASC_RESP_SLVERR = 2'h2;

endpackage

// ### hw/asc_div_if.sv
`timescale 1ns/1ps
`default_nettype none
// divisor settings in, divided clocks out
interface asc_div_if;
  logic [7:0] bit_clock_divisor;
  logic [2:0] master_clock_divisor;
  logic master_mode;
  logic bclk;
  logic bclk_edge;
  logic mclk_div;
  modport ctl (
    output bit_clock_divisor,
    output master_clock_divisor,
    output master_mode,
    input bclk,
    input bclk_edge,
    input mclk_div
  );
  modport div (
    input bit_clock_divisor,
    input master_clock_divisor,
    input master_mode,
    output bclk,
    output bclk_edge,
    output mclk_div
  );
endinterface
`default_nettype wire

// ### hw/asc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module asc_clk_div
  import asc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings and divided clocks
  asc_div_if.div dv
);

  logic [ASC_BCD_W-1:0] bcnt_ff;
  logic bclk_ff;
  logic bedge_ff;
  logic [ASC_MCD_W-1:0] mcnt_ff;
  logic mclk_ff;
  logic bwrap;
  logic mwrap;

  // half period ends; >= copes with a divisor lowered mid count
  assign bwrap = (bcnt_ff >= dv.bit_clock_divisor);
  assign mwrap = (mcnt_ff >= ASC_MCD_W'(dv.master_clock_divisor - 3'h1));

  // bit clock: half period of divisor+1 cycles, idle low in slave mode
  always_ff @(posedge aclk) begin
    if (!aresetn || !dv.master_mode) begin
      bcnt_ff <= '0;
      bclk_ff <= 1'b0;
      bedge_ff <= 1'b0;
    end else if (bwrap) begin
      bcnt_ff <= '0;
      bclk_ff <= ~bclk_ff;
      bedge_ff <= 1'b1;
    end else begin
      bcnt_ff <= ASC_BCD_W'(bcnt_ff + 1'b1);
      bedge_ff <= 1'b0;
    end
  end

  // master clock: half period of divisor cycles, held low at divisor zero
  always_ff @(posedge aclk) begin
    if (!aresetn || dv.master_clock_divisor == 3'h0) begin
      mcnt_ff <= '0;
      mclk_ff <= 1'b0;
    end else if (mwrap) begin
      mcnt_ff <= '0;
      mclk_ff <= ~mclk_ff;
    end else begin
      mcnt_ff <= ASC_MCD_W'(mcnt_ff + 1'b1);
    end
  end

  assign dv.bclk = bclk_ff;
  assign dv.bclk_edge = bedge_ff;
  assign dv.mclk_div = mclk_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_bclk_toggle;
    @(posedge aclk) disable iff (!aresetn)
    (dv.master_mode && bcnt_ff == dv.bit_clock_divisor) ##1 dv.master_mode
    |-> $changed(bclk_ff) && bedge_ff;
  endproperty
  a_bclk_toggle: assert property (p_bclk_toggle) else $error("bit clock missed toggle");

  property p_bclk_hold;
    @(posedge aclk) disable iff (!aresetn)
    (dv.master_mode && bcnt_ff < dv.bit_clock_divisor) ##1 dv.master_mode
    |-> $stable(bclk_ff) && !bedge_ff;
  endproperty
  a_bclk_hold: assert property (p_bclk_hold) else $error("bit clock toggled early");

  property p_bclk_slave;
    @(posedge aclk) disable iff (!aresetn)
    !dv.master_mode |=> !bclk_ff && !bedge_ff;
  endproperty
  a_bclk_slave: assert property (p_bclk_slave) else $error("bit clock ran in slave mode");

  property p_mclk_zero;
    @(posedge aclk) disable iff (!aresetn)
    dv.master_clock_divisor == 3'h0 |=> !mclk_ff;
  endproperty
  a_mclk_zero: assert property (p_mclk_zero) else $error("divided master clock not idle");

  property p_mclk_toggle;
    @(posedge aclk) disable iff (!aresetn)
    (dv.master_clock_divisor != 3'h0 && mcnt_ff == dv.master_clock_divisor - 3'h1)
    ##1 $stable(dv.master_clock_divisor) |-> $changed(mclk_ff);
  endproperty
  a_mclk_toggle: assert property (p_mclk_toggle) else $error("master clock missed toggle");

endmodule
`default_nettype wire

// ### verif/asc_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// codec side: measures the clocks it receives
// ----------------------------------------------------------------
module asc_codec_model (
  // clocks from the block
  input wire logic aclk,
  input wire logic bclk,
  input wire logic mclk,
  // measured periods in aclk cycles
  output int bclk_per,
  output int mclk_per
);
  int bcnt = 0;
  int mcnt = 0;
  logic bq = 1'b0;
  logic mq = 1'b0;
  // cycles between rising edges; only valid for a divided master clock
  always @(posedge aclk) begin
    bq <= bclk;
    mq <= mclk;
    bcnt <= (bclk && !bq) ? 1 : bcnt + 1;
    mcnt <= (mclk && !mq) ? 1 : mcnt + 1;
    if (bclk && !bq) bclk_per <= bcnt;
    if (mclk && !mq) mclk_per <= mcnt;
  end
endmodule
`default_nettype wire

// ### verif/audio_serial_clkdiv_irq_enable_tb.sv
`timescale 1ns/1ps
`default_nettype none
module audio_serial_clkdiv_irq_enable_tb
  import asc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ien;
    logic [4:0] flg;
    logic [3:0] txl;
    logic [3:0] rxl;
    logic exp;
  } asc_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic master_mode = 1'b0;
  logic [3:0] tx_level = 4'h4, rx_level = 4'h0;
  logic [2:0] tx_level_threshold = 3'h3, rx_level_threshold = 3'h3;
  logic left_zero_cross_flag = 1'b0, right_zero_cross_flag = 1'b0;
  logic tx_overflow_flag = 1'b0, tx_underflow_flag = 1'b0, rx_overflow_flag = 1'b0;
  logic rx_fifo_read = 1'b0, rx_fifo_empty = 1'b0;
  logic rx_underflow_flag, bit_clock, bit_clock_edge, master_clock, irq;
  int bclk_per, mclk_per;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_edge = 0;
  // enable word, flags {lzc,rzc,txov,txud,rxov}, tx level, rx level, irq
  asc_row_t rows [13] = '{
    '{16'h1000, 5'b10000, 4'h4, 4'h0, 1'b1},
    '{16'h0000, 5'b10000, 4'h4, 4'h0, 1'b0},
    '{16'h0800, 5'b01000, 4'h4, 4'h0, 1'b1},
    '{16'h1000, 5'b01000, 4'h4, 4'h0, 1'b0},
    '{16'h0400, 5'b00000, 4'h2, 4'h0, 1'b1},
    '{16'h0400, 5'b00000, 4'h3, 4'h0, 1'b0},
    '{16'h0200, 5'b00100, 4'h4, 4'h0, 1'b1},
    '{16'h0100, 5'b00010, 4'h4, 4'h0, 1'b1},
    '{16'h0004, 5'b00000, 4'h4, 4'h3, 1'b1},
    '{16'h0004, 5'b00000, 4'h4, 4'h2, 1'b0},
    '{16'h0002, 5'b00001, 4'h4, 4'h0, 1'b1},
    '{16'h0001, 5'b00001, 4'h4, 4'h0, 1'b0},
    '{16'h1f06, 5'b00000, 4'h4, 4'h2, 1'b0}
  };

  // ----------------------------------------------------------------
  // block and codec
  // ----------------------------------------------------------------
  asc_top #(.LEVEL_W(4), .TH_W(3)) i_asc_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .master_mode, .tx_level, .rx_level, .tx_level_threshold, .rx_level_threshold,
    .left_zero_cross_flag, .right_zero_cross_flag, .tx_overflow_flag,
    .tx_underflow_flag, .rx_overflow_flag, .rx_fifo_read, .rx_fifo_empty,
    .rx_underflow_flag, .bit_clock, .bit_clock_edge, .master_clock, .irq
  );
  asc_codec_model i_asc_codec_model (
    .aclk, .bclk(bit_clock), .mclk(master_clock), .bclk_per, .mclk_per
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // write one word, compare the response code
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // read one word, compare data and response code
  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  // ----------------------------------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------------------------------
  initial forever #2.5 aclk = ~aclk;
  // cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("irq_rst", 32'h0, {31'h0, irq});
    chk("bclk_rst", 32'h0, {31'h0, bit_clock});
    rchk(ASC_OFF_IEN, 32'h0, ASC_RESP_OKAY);
    rchk(ASC_OFF_CLKDIV, 32'h0, ASC_RESP_OKAY);
    wr(ASC_OFF_IEN, 32'hffff_ffff, ASC_RESP_OKAY);
    rchk(ASC_OFF_IEN, 32'h0000_1f07, ASC_RESP_OKAY);
    wr(ASC_OFF_CLKDIV, 32'hffff_ffff, ASC_RESP_OKAY);
    rchk(ASC_OFF_CLKDIV, 32'h0000_ff07, ASC_RESP_OKAY);
    // lane 1 only: bit divisor replaced, master divisor kept
    s_axi_wstrb <= 4'h2;
    wr(ASC_OFF_CLKDIV, 32'h0000_aa05, ASC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rchk(ASC_OFF_CLKDIV, 32'h0000_aa07, ASC_RESP_OKAY);
    wr(8'h20, 32'h1234_5678, ASC_RESP_SLVERR);
    rchk(8'h20, 32'h0, ASC_RESP_SLVERR);
    // event gating table
    foreach (rows[i]) begin
      wr(ASC_OFF_IEN, {16'h0, rows[i].ien}, ASC_RESP_OKAY);
      @(posedge aclk);
      {left_zero_cross_flag, right_zero_cross_flag, tx_overflow_flag,
       tx_underflow_flag, rx_overflow_flag} <= rows[i].flg;
      tx_level <= rows[i].txl;
      rx_level <= rows[i].rxl;
      repeat (3) @(posedge aclk);
      chk("irq", {31'h0, rows[i].exp}, {31'h0, irq});
    end
    @(posedge aclk);
    {left_zero_cross_flag, right_zero_cross_flag, tx_overflow_flag,
     tx_underflow_flag, rx_overflow_flag} <= 5'b00000;
    tx_level <= 4'h4;
    rx_level <= 4'h0;
    // divided clocks: bit divisor 3, master divisor 6
    wr(ASC_OFF_CLKDIV, 32'h0000_0306, ASC_RESP_OKAY);
    repeat (20) begin
      @(posedge aclk);
      chk("bclk_idle", 32'h0, {31'h0, bit_clock});
      chk("bedge_idle", 32'h0, {31'h0, bit_clock_edge});
    end
    master_mode <= 1'b1;
    repeat (40) @(posedge aclk);
    chk("bclk_per", 32'd8, bclk_per);
    chk("mclk_per", 32'd12, mclk_per);
    // one edge pulse per half period of four cycles
    repeat (16) begin
      @(posedge aclk);
      n_edge = n_edge + int'(bit_clock_edge);
    end
    chk("bclk_edges", 32'd4, n_edge);
    wr(ASC_OFF_CLKDIV, 32'h0000_0001, ASC_RESP_OKAY);
    repeat (20) @(posedge aclk);
    chk("bclk_per", 32'd2, bclk_per);
    chk("mclk_per", 32'd2, mclk_per);
    wr(ASC_OFF_CLKDIV, 32'h0000_0000, ASC_RESP_OKAY);
    repeat (4) begin
      @(posedge aclk);
      #1 chk("mclk_hi", 32'h1, {31'h0, master_clock});
      #2.5 chk("mclk_lo", 32'h0, {31'h0, master_clock});
    end
    @(posedge aclk);
    master_mode <= 1'b0;
    // receive underflow: read while not empty, then while empty
    wr(ASC_OFF_IEN, 32'h0000_0001, ASC_RESP_OKAY);
    @(posedge aclk);
    rx_fifo_read <= 1'b1;
    @(posedge aclk);
    rx_fifo_read <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("rxud_nonempty", 32'h0, {31'h0, rx_underflow_flag});
    @(posedge aclk);
    rx_fifo_empty <= 1'b1;
    rx_fifo_read <= 1'b1;
    @(posedge aclk);
    rx_fifo_read <= 1'b0;
    @(posedge aclk);
    chk("rxud_set", 32'h1, {31'h0, rx_underflow_flag});
    @(posedge aclk);
    chk("irq_rxud", 32'h1, {31'h0, irq});
    rchk(ASC_OFF_STATUS, 32'h0000_0001, ASC_RESP_OKAY);
    wr(ASC_OFF_IEN, 32'h0000_0000, ASC_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq_rxud_off", 32'h0, {31'h0, irq});
    wr(ASC_OFF_STATUS, 32'h0000_0001, ASC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("rxud_clr", 32'h0, {31'h0, rx_underflow_flag});
    end_sim;
  end
endmodule
`default_nettype wire
